/* File: rtl/timer_gate_defs.svh */
// Constants for the gated sixteen-bit counter
`ifndef TIMER_GATE_DEFS_SVH
`define TIMER_GATE_DEFS_SVH
`define CS_INSTR 2'h0
`define CS_SYSTEM 2'h1
`define CS_EXTERNAL 2'h2
`define CS_LFOSC 2'h3
`define GS_PIN 2'h0
`define GS_COMPANION 2'h1
`define GS_PERIOD 2'h2
`define GS_RESERVED 2'h3
`define INSTR_DIV 2'h3
`define COUNT_RESET 16'h0000
`define COUNT_MAX 16'hffff
`define COMPANION_MAX 8'hff
`define COMPANION_ZERO 8'h00
`endif

/* File: rtl/timer_gate_pkg.sv */
// Types for the gated sixteen-bit counter
package timer_gate_pkg;
  typedef enum logic [2:0] {
    sp_idle = 3'b001,
    sp_wait = 3'b010,
    sp_run = 3'b100
  } single_pulse_state_t;
endpackage : timer_gate_pkg

/* File: rtl/gate_link_if.sv */
// Gate and tick signals shared between counter modules
`timescale 1ns/1ps
interface gate_link_if;
  logic tick;
  logic gate_level;
  logic count_enable;
  logic gate_fall;
  modport gate (input tick, output gate_level, output count_enable,
                output gate_fall);
  modport core (output tick, input gate_level, input count_enable,
                input gate_fall);
endinterface : gate_link_if

/* File: rtl/clock_select.sv */
// Counter clock selection and prescaler
`timescale 1ns/1ps
`include "timer_gate_defs.svh"
module clock_select (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Configuration
  input wire logic [1:0] clock_source_select,
  input wire logic [1:0] prescale_select,
  input wire logic ext_clock_sync_bypass,
  input wire logic prescale_clear,
  // Clock sources
  input wire logic ext_clock_pin,
  input wire logic low_freq_internal_osc,
  // Result
  output logic tick
);
  logic [1:0] instr_div;
  logic [2:0] prescale;
  logic ext_prev;
  logic lf_prev;
  logic raw_tick;
  logic [2:0] mask;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      instr_div <= 2'h0;
      ext_prev <= 1'b0;
      lf_prev <= 1'b0;
    end else begin
      instr_div <= instr_div + 2'h1;
      ext_prev <= ext_clock_pin;
      lf_prev <= low_freq_internal_osc;
    end
  end

  // Bypass uses the edge straight from the pin, sync adds a stage
  logic ext_sync_prev;
  logic ext_edge;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ext_sync_prev <= 1'b0;
    end else begin
      ext_sync_prev <= ext_prev;
    end
  end
  assign ext_edge = ext_clock_sync_bypass
                  ? (ext_clock_pin & ~ext_prev)
                  : (ext_prev & ~ext_sync_prev);

  always_comb begin
    case (clock_source_select)
      `CS_INSTR: raw_tick = (instr_div == `INSTR_DIV);
      `CS_SYSTEM: raw_tick = 1'b1;
      `CS_EXTERNAL: raw_tick = ext_edge;
      default: raw_tick = low_freq_internal_osc & ~lf_prev;
    endcase
  end

  assign mask = {prescale_select[1] & prescale_select[0], prescale_select[1],
                 prescale_select[1] | prescale_select[0]};

  always_ff @(posedge mclk) begin
    if (!reset_n || prescale_clear) begin
      prescale <= 3'h0;
      tick <= 1'b0;
    end else begin
      tick <= raw_tick && ((prescale & mask) == mask);
      if (raw_tick) begin
        prescale <= prescale + 3'h1;
      end
    end
  end
endmodule : clock_select

/* File: rtl/gate_unit.sv */
// Gate source, polarity, toggle and single-pulse logic
`timescale 1ns/1ps
`include "timer_gate_defs.svh"
module gate_unit (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Configuration
  input wire logic timer_on_bit,
  input wire logic gate_enable_bit,
  input wire logic gate_polarity_bit,
  input wire logic gate_toggle_bit,
  input wire logic gate_single_pulse_bit,
  input wire logic [1:0] gate_source_select,
  input wire logic arm_set,
  input wire logic arm_clear,
  output logic single_pulse_arm_bit,
  // Gate sources
  input wire logic gate_pin,
  input wire logic companion_wrap,
  input wire logic period_match,
  // Link to core
  gate_link_if.gate link
);
  logic source;
  logic source_prev;
  logic toggle_ff;
  logic gate_pre;
  logic gate_prev;
  logic gate_rise;
  timer_gate_pkg::single_pulse_state_t sp_state;

  always_comb begin
    case (gate_source_select)
      `GS_PIN: source = gate_pin;
      `GS_COMPANION: source = companion_wrap;
      `GS_PERIOD: source = period_match;
      default: source = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      source_prev <= 1'b0;
    end else begin
      source_prev <= source;
    end
  end

  // Toggle flip-flop on rising edge of polarity-corrected source
  always_ff @(posedge mclk) begin
    if (!reset_n || !gate_toggle_bit || !timer_on_bit) begin
      toggle_ff <= 1'b0;
    end else if ((source ^ ~gate_polarity_bit) &&
                 !(source_prev ^ ~gate_polarity_bit)) begin
      toggle_ff <= ~toggle_ff;
    end
  end

  assign gate_pre = gate_toggle_bit ? toggle_ff
                                    : (source ^ ~gate_polarity_bit);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      gate_prev <= 1'b0;
    end else begin
      gate_prev <= gate_pre;
    end
  end
  assign gate_rise = gate_pre & ~gate_prev;

  // Single-pulse: arm, wait for rising gate, run until falling
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sp_state <= timer_gate_pkg::sp_idle;
      single_pulse_arm_bit <= 1'b0;
    end else begin
      case (sp_state)
        timer_gate_pkg::sp_idle: begin
          if (arm_set && gate_single_pulse_bit) begin
            single_pulse_arm_bit <= 1'b1;
            sp_state <= timer_gate_pkg::sp_wait;
          end
        end
        timer_gate_pkg::sp_wait: begin
          if (arm_clear) begin
            single_pulse_arm_bit <= 1'b0;
            sp_state <= timer_gate_pkg::sp_idle;
          end else if (gate_rise) begin
            sp_state <= timer_gate_pkg::sp_run;
          end
        end
        timer_gate_pkg::sp_run: begin
          if (!gate_pre || arm_clear) begin
            single_pulse_arm_bit <= 1'b0;
            sp_state <= timer_gate_pkg::sp_idle;
          end
        end
        default: begin
          sp_state <= timer_gate_pkg::sp_idle;
          single_pulse_arm_bit <= 1'b0;
        end
      endcase
    end
  end

  logic level;
  logic level_prev;
  assign level = gate_single_pulse_bit
               ? (gate_pre && (sp_state == timer_gate_pkg::sp_run ||
                  (sp_state == timer_gate_pkg::sp_wait && gate_rise)))
               : gate_pre;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      level_prev <= 1'b0;
    end else begin
      level_prev <= level;
    end
  end

  assign link.gate_level = level;
  assign link.gate_fall = level_prev & ~level;
  assign link.count_enable = timer_on_bit &&
                             (!gate_enable_bit || level);
endmodule : gate_unit

/* File: rtl/gated_sixteen_bit_counter.sv */
// Gated sixteen-bit timer/counter top level
`timescale 1ns/1ps
`include "timer_gate_defs.svh"
module gated_sixteen_bit_counter #(
  parameter int COUNT_WIDTH = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Control
  input wire logic timer_on_bit,
  input wire logic [1:0] clock_source_select,
  input wire logic [1:0] prescale_select,
  input wire logic secondary_osc_enable,
  input wire logic ext_clock_sync_bypass,
  input wire logic gate_enable_bit,
  input wire logic gate_polarity_bit,
  input wire logic gate_toggle_bit,
  input wire logic gate_single_pulse_bit,
  input wire logic [1:0] gate_source_select,
  input wire logic arm_set,
  input wire logic arm_clear,
  // Interrupt enables and sleep
  input wire logic overflow_irq_enable,
  input wire logic gate_event_irq_enable,
  input wire logic peripheral_irq_enable,
  input wire logic global_irq_enable,
  input wire logic sleep_mode,
  // Count byte access
  input wire logic count_low_write,
  input wire logic count_high_write,
  input wire logic [7:0] write_data,
  input wire logic overflow_flag_clear,
  input wire logic gate_event_flag_clear,
  // Pins and peer events
  input wire logic ext_clock_pin,
  input wire logic low_freq_internal_osc,
  input wire logic gate_pin,
  input wire logic [7:0] companion_eight_bit_count,
  input wire logic companion_increment,
  input wire logic period_match,
  input wire logic capture_event,
  input wire logic compare_enable,
  input wire logic special_event_trigger,
  // Status
  output logic [7:0] count_low_byte,
  output logic [7:0] count_high_byte,
  output logic [COUNT_WIDTH-1:0] capture_compare_value,
  output logic compare_match,
  output logic single_pulse_arm_bit,
  output logic gate_level_status,
  output logic overflow_flag,
  output logic gate_event_flag,
  output logic irq_request,
  output logic wake_request,
  output logic secondary_osc_run
);
  gate_link_if link ();
  logic [COUNT_WIDTH-1:0] count;
  logic count_write;
  logic run_ok;
  logic companion_wrap;
  logic arm_raw;
  logic increment;
  logic rollover;

  assign count_write = count_low_write | count_high_write;
  assign companion_wrap = companion_increment &&
                          (companion_eight_bit_count == `COMPANION_MAX);

  // Only unsynchronized external clocking survives sleep
  assign run_ok = !sleep_mode ||
                  (ext_clock_sync_bypass &&
                   clock_source_select == `CS_EXTERNAL);

  clock_select u_clock (
    .mclk(mclk),
    .reset_n(reset_n),
    .clock_source_select(clock_source_select),
    .prescale_select(prescale_select),
    .ext_clock_sync_bypass(ext_clock_sync_bypass),
    .prescale_clear(count_write),
    .ext_clock_pin(ext_clock_pin),
    .low_freq_internal_osc(low_freq_internal_osc),
    .tick(link.tick)
  );

  gate_unit u_gate (
    .mclk(mclk),
    .reset_n(reset_n),
    .timer_on_bit(timer_on_bit),
    .gate_enable_bit(gate_enable_bit),
    .gate_polarity_bit(gate_polarity_bit),
    .gate_toggle_bit(gate_toggle_bit),
    .gate_single_pulse_bit(gate_single_pulse_bit),
    .gate_source_select(gate_source_select),
    .arm_set(arm_set),
    .arm_clear(arm_clear),
    .single_pulse_arm_bit(arm_raw),
    .gate_pin(gate_pin),
    .companion_wrap(companion_wrap),
    .period_match(period_match),
    .link(link)
  );

  assign increment = link.tick && link.count_enable && run_ok;
  assign rollover = increment &&
                    (count == COUNT_WIDTH'(`COUNT_MAX));

  // Count register: byte writes beat special trigger clear
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      count <= COUNT_WIDTH'(`COUNT_RESET);
    end else if (count_low_write) begin
      count[7:0] <= write_data;
    end else if (count_high_write) begin
      count[15:8] <= write_data;
    end else if (special_event_trigger) begin
      count <= COUNT_WIDTH'(`COUNT_RESET);
    end else if (increment) begin
      count <= count + COUNT_WIDTH'(1);
    end
  end

  // Byte views are registered so each read is a clean value
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      count_low_byte <= 8'h00;
      count_high_byte <= 8'h00;
    end else begin
      count_low_byte <= count[7:0];
      count_high_byte <= count[15:8];
    end
  end

  // Capture copy and compare equality
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      capture_compare_value <= COUNT_WIDTH'(`COUNT_RESET);
      compare_match <= 1'b0;
    end else begin
      if (capture_event) begin
        capture_compare_value <= count;
      end
      compare_match <= compare_enable &&
                       (count == capture_compare_value);
    end
  end

  // Status resynchronised onto the register side
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      gate_level_status <= 1'b0;
      single_pulse_arm_bit <= 1'b0;
      secondary_osc_run <= 1'b0;
    end else begin
      gate_level_status <= link.gate_level;
      single_pulse_arm_bit <= arm_raw;
      secondary_osc_run <= secondary_osc_enable;
    end
  end

  // Sticky flags: hardware set wins over software clear
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      overflow_flag <= 1'b0;
    end else if (rollover && !special_event_trigger && !count_write) begin
      overflow_flag <= 1'b1;
    end else if (overflow_flag_clear) begin
      overflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      gate_event_flag <= 1'b0;
    end else if (link.gate_fall) begin
      gate_event_flag <= 1'b1;
    end else if (gate_event_flag_clear) begin
      gate_event_flag <= 1'b0;
    end
  end

  logic ovf_pending;
  logic gate_pending;
  assign ovf_pending = overflow_flag && overflow_irq_enable && timer_on_bit;
  assign gate_pending = gate_event_flag && gate_event_irq_enable;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      irq_request <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      irq_request <= (ovf_pending || gate_pending) &&
                     peripheral_irq_enable && global_irq_enable;
      wake_request <= sleep_mode && peripheral_irq_enable &&
                      (ovf_pending || gate_pending);
    end
  end
endmodule : gated_sixteen_bit_counter

/* File: dv/count_clock_source.sv */
// Pin-side model of the external and low-frequency count clocks
`timescale 1ns/1ps
module count_clock_source (
  // Clock and burst enable
  input wire logic mclk,
  input wire logic run,
  // Pins
  output logic ext_clock_pin,
  output logic low_freq_internal_osc
);
  logic [1:0] phase = 2'h0;
  // Four-cycle period, parked low between bursts
  always @(negedge mclk) begin
    phase <= run ? phase + 2'h1 : 2'h0;
  end
  assign ext_clock_pin = phase[1];
  assign low_freq_internal_osc = phase[1];
endmodule : count_clock_source

/* File: dv/gated_sixteen_bit_counter_assertions.sv */
// Port-level checks for the gated sixteen-bit counter
`timescale 1ns/1ps
module gated_sixteen_bit_counter_assertions #(
  parameter int COUNT_WIDTH = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Control
  input wire logic timer_on_bit,
  input wire logic gate_enable_bit,
  input wire logic gate_polarity_bit,
  input wire logic gate_toggle_bit,
  input wire logic arm_set,
  input wire logic gate_single_pulse_bit,
  input wire logic special_event_trigger,
  input wire logic [1:0] gate_source_select,
  input wire logic overflow_irq_enable,
  input wire logic peripheral_irq_enable,
  input wire logic global_irq_enable,
  input wire logic overflow_flag_clear,
  input wire logic count_low_write,
  input wire logic count_high_write,
  // Data and status
  input wire logic [7:0] write_data,
  input wire logic [7:0] count_low_byte,
  input wire logic [7:0] count_high_byte,
  input wire logic single_pulse_arm_bit,
  input wire logic gate_level_status,
  input wire logic overflow_flag,
  input wire logic gate_event_flag,
  input wire logic irq_request
);
  logic [15:0] count;
  logic idle;
  assign count = {count_high_byte, count_low_byte};
  assign idle = !count_low_write && !count_high_write;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  a_hold_when_off: assert property (
    (!timer_on_bit && idle && !special_event_trigger) [*3]
    |=> $stable(count)) else $error("count moved while stopped");
  a_reserved_gate_low: assert property (
    (timer_on_bit && gate_enable_bit && gate_polarity_bit && idle &&
     gate_source_select == 2'h3 && !gate_toggle_bit &&
     !gate_single_pulse_bit && !special_event_trigger) [*5]
    |=> $stable(count)) else $error("count moved with gate low");
  a_trigger_clears: assert property (
    special_event_trigger && idle |-> ##2 count == 16'h0000)
    else $error("trigger did not clear count");
  a_write_beats_trigger: assert property (
    special_event_trigger && count_low_write && !count_high_write
    |-> ##2 count_low_byte == $past(write_data, 2))
    else $error("trigger overrode byte write");
  a_arm_needs_mode: assert property (
    $rose(single_pulse_arm_bit) |-> $past(arm_set, 2) &&
    $past(gate_single_pulse_bit, 2)) else $error("arm without request");
  a_fall_sets_flag: assert property (
    $fell(gate_level_status) |-> ##[0:3] gate_event_flag)
    else $error("gate fall left flag clear");
  a_flag_sticky: assert property (
    overflow_flag && !overflow_flag_clear |=> overflow_flag)
    else $error("overflow flag dropped");
  a_wrap_sets_flag: assert property (
    $past(count) == 16'hffff && count == 16'h0000 &&
    !$past(special_event_trigger, 2) |-> ##[0:1] overflow_flag)
    else $error("rollover left flag clear");
  a_irq_follows_flag: assert property (
    overflow_flag && overflow_irq_enable && peripheral_irq_enable &&
    global_irq_enable && timer_on_bit |=> irq_request)
    else $error("enabled overflow raised no request");

  c_wrap: cover property (overflow_flag);
  c_armed: cover property (single_pulse_arm_bit);
  c_gate_fall: cover property ($fell(gate_level_status));
endmodule : gated_sixteen_bit_counter_assertions

bind gated_sixteen_bit_counter gated_sixteen_bit_counter_assertions
  #(.COUNT_WIDTH(COUNT_WIDTH)) i_checks (.*);

/* File: dv/gated_sixteen_bit_counter_tb.sv */
// Self-checking bench for the gated sixteen-bit counter
`timescale 1ns/1ps
module gated_sixteen_bit_counter_tb;
  logic mclk = 1'b0, reset_n = 1'b0, timer_on_bit = 1'b0;
  logic secondary_osc_enable = 1'b0, ext_clock_sync_bypass = 1'b0;
  logic gate_enable_bit = 1'b0, gate_polarity_bit = 1'b0;
  logic gate_toggle_bit = 1'b0, gate_single_pulse_bit = 1'b0;
  logic arm_set = 1'b0, arm_clear = 1'b0, overflow_irq_enable = 1'b1;
  logic gate_event_irq_enable = 1'b0, peripheral_irq_enable = 1'b1;
  logic global_irq_enable = 1'b1, sleep_mode = 1'b0, gate_pin = 1'b0;
  logic count_low_write = 1'b0, count_high_write = 1'b0;
  logic overflow_flag_clear = 1'b0, gate_event_flag_clear = 1'b0;
  logic companion_increment = 1'b0, period_match = 1'b0;
  logic capture_event = 1'b0, compare_enable = 1'b0;
  logic special_event_trigger = 1'b0, clk_run = 1'b0;
  logic [1:0] clock_source_select = 2'h0, prescale_select = 2'h0;
  logic [1:0] gate_source_select = 2'h0;
  logic [7:0] write_data = 8'h00, companion_eight_bit_count = 8'h00;
  logic ext_clock_pin, low_freq_internal_osc, compare_match;
  logic single_pulse_arm_bit, gate_level_status, overflow_flag;
  logic gate_event_flag, irq_request, wake_request, secondary_osc_run;
  logic [7:0] count_low_byte, count_high_byte, bits;
  logic [15:0] capture_compare_value, v, rnd = 16'h0d73;
  logic [16:0] fin;
  logic [19:0] notes[$];
  int bad_count = 0, checks_done = 0, cycles = 0, per, n;
  event look;

  gated_sixteen_bit_counter i_dut (.*);
  count_clock_source i_src (.mclk, .run(clk_run), .ext_clock_pin,
    .low_freq_internal_osc);

  assign bits = {secondary_osc_run, compare_match, single_pulse_arm_bit,
    gate_level_status, gate_event_flag, irq_request, overflow_flag,
    wake_request};

  always #12.5 mclk = ~mclk;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic wait_n(input int k);
    repeat (k) @(negedge mclk);
  endtask : wait_n

  task automatic pulse(ref logic s);
    s = 1'b1;
    wait_n(1);
    s = 1'b0;
  endtask : pulse

  task automatic note(input logic [3:0] s, input logic [15:0] e);
    notes.push_back({s, e});
    ->look;
  endtask : note

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : close_out

  // Stops, settles, then loads both bytes and clears flags
  task automatic load(input logic [15:0] d);
    timer_on_bit = 1'b0;
    clk_run = 1'b0;
    wait_n(3);
    write_data = d[7:0];
    pulse(count_low_write);
    write_data = d[15:8];
    pulse(count_high_write);
    pulse(overflow_flag_clear);
    pulse(gate_event_flag_clear);
    wait_n(3);
  endtask : load

  always @(look) begin
    logic [19:0] e;
    while (notes.size() > 0) begin
      e = notes.pop_front();
      if (e[19:16] == 4'h0) begin
        check({count_high_byte, count_low_byte}, e[15:0]);
      end else if (e[19:16] == 4'h8) begin
        check(capture_compare_value, e[15:0]);
      end else if (e[19:16] == 4'h9) begin
        check({15'h0, bits[0]}, e[15:0]);
      end else begin
        check({15'h0, bits[e[18:16]]}, e[15:0]);
      end
    end
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      close_out();
    end
  end

  initial begin
    wait_n(10);
    reset_n = 1'b1;
    wait_n(1);
    for (int i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      v = i[0] ? 16'hfffc : {1'b0, rnd[14:0]};
      fin = {1'b0, v} + 17'h00007;
      load(v);
      clock_source_select = i[3:2];
      prescale_select = i[1:0];
      ext_clock_sync_bypass = i[0];
      sleep_mode = i[3:2] == 2'h2 && i[0];
      global_irq_enable = i != 13;
      gate_enable_bit = i[1];
      gate_polarity_bit = 1'b1;
      gate_pin = 1'b1;
      per = (i[3:2] == 2'h1 ? 1 : 4) << i[1:0];
      timer_on_bit = 1'b1;
      clk_run = 1'b1;
      n = 0;
      while ({count_high_byte, count_low_byte} === v && n < 300) begin
        wait_n(1);
        n++;
      end
      wait_n(6 * per);
      note(4'h0, fin[15:0]);
      wait_n(3);
      note(4'h1, {15'h0, fin[16]});
      note(4'h2, {15'h0, fin[16] && i != 13});
      note(4'h9, {15'h0, fin[16] && sleep_mode});
      $display("count test %0d done", i);
    end
    for (int j = 0; j < 4; j++) begin
      load(rnd);
      clock_source_select = 2'h1;
      prescale_select = 2'h0;
      gate_enable_bit = j < 3;
      gate_polarity_bit = j != 1;
      gate_source_select = j == 2 ? 2'h3 : 2'h0;
      gate_pin = j == 1;
      sleep_mode = j == 3;
      secondary_osc_enable = j == 3;
      timer_on_bit = 1'b1;
      wait_n(12);
      note(4'h0, rnd);
      note(4'h7, {15'h0, j == 3});
      $display("hold test %0d done", j);
    end
    gate_enable_bit = 1'b0;
    gate_polarity_bit = 1'b1;
    sleep_mode = 1'b0;
    secondary_osc_enable = 1'b0;
    companion_eight_bit_count = 8'hff;
    pulse(gate_event_flag_clear);
    for (int k = 0; k < 3; k++) begin
      gate_source_select = k[1:0];
      gate_toggle_bit = k != 0;
      for (int m = 0; m < 2; m++) begin
        if (k == 0) gate_pin = m == 0;
        else if (k == 1) pulse(companion_increment);
        else pulse(period_match);
        wait_n(4);
        note(4'h4, {15'h0, m == 0});
      end
      note(4'h3, 16'h0001);
      pulse(gate_event_flag_clear);
    end
    pulse(period_match);
    gate_toggle_bit = 1'b0;
    wait_n(4);
    note(4'h4, 16'h0000);
    gate_source_select = 2'h1;
    gate_toggle_bit = 1'b1;
    companion_eight_bit_count = 8'hfe;
    pulse(companion_increment);
    wait_n(4);
    note(4'h4, 16'h0000);
    gate_toggle_bit = 1'b0;
    gate_source_select = 2'h0;
    gate_enable_bit = 1'b1;
    gate_single_pulse_bit = 1'b1;
    pulse(gate_event_flag_clear);
    pulse(arm_set);
    wait_n(2);
    note(4'h5, 16'h0001);
    for (int p = 0; p < 2; p++) begin
      gate_pin = 1'b1;
      wait_n(5);
      gate_pin = 1'b0;
      wait_n(5);
      note(4'h5, 16'h0000);
      note(4'h3, {15'h0, p == 0});
      pulse(gate_event_flag_clear);
    end
    overflow_irq_enable = 1'b0;
    gate_event_irq_enable = 1'b1;
    gate_toggle_bit = 1'b1;
    pulse(arm_set);
    for (int q = 0; q < 2; q++) begin
      gate_pin = 1'b1;
      wait_n(5);
      gate_pin = 1'b0;
      wait_n(5);
      note(4'h5, {15'h0, q == 0});
      note(4'h2, {15'h0, q == 1});
    end
    gate_toggle_bit = 1'b0;
    gate_single_pulse_bit = 1'b0;
    pulse(arm_clear);
    $display("gate tests done");
    v = lfsr(rnd);
    load(v);
    pulse(capture_event);
    wait_n(2);
    note(4'h8, v);
    compare_enable = 1'b1;
    wait_n(2);
    note(4'h6, 16'h0001);
    compare_enable = 1'b0;
    pulse(special_event_trigger);
    wait_n(2);
    note(4'h0, 16'h0000);
    note(4'h1, 16'h0000);
    load(v);
    write_data = rnd[7:0];
    special_event_trigger = 1'b1;
    pulse(count_low_write);
    special_event_trigger = 1'b0;
    wait_n(2);
    note(4'h0, {v[15:8], rnd[7:0]});
    $display("trigger tests done");
    wait_n(1);
    close_out();
  end
endmodule : gated_sixteen_bit_counter_tb
